// ==== rtl/ccd_map.svh ====
// Purpose: Register addresses, field positions and reset values of the command decoder
// Assumes: Included by its bare name from the package, ccd_exec and ccd_top
// Notes:   Addresses are the 5-bit register addresses of the packet interface
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define CCD_ADDR_CRC      5'h00
`define CCD_ADDR_FAR      5'h01
`define CCD_ADDR_CMD      5'h04
`define CCD_ADDR_OPT0     5'h09

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CCD_C_NULL        5'h00
`define CCD_C_WRITE       5'h01
`define CCD_C_MULTI       5'h02
`define CCD_C_LAST        5'h03
`define CCD_C_READ        5'h04
`define CCD_C_START       5'h05
`define CCD_C_ULTRA_RAM_CLEAR_COMMAND        5'h06
`define CCD_C_CRCRST      5'h07
`define CCD_C_HOLD        5'h08
`define CCD_C_SWITCH      5'h09
`define CCD_C_RESTORE     5'h0A
`define CCD_C_SHUTDOWN    5'h0B
`define CCD_C_DESYNCHRONIZE_COMMAND      5'h0D
`define CCD_C_WARMBOOT    5'h0F
`define CCD_C_RECALC      5'h10
`define CCD_C_REREAD      5'h12
`define CCD_C_FALLEDGE    5'h13

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CCD_CMD_W         5
`define CCD_OPT0_ECLK_BIT 0
`define CCD_OPT0_FSEL_LSB 1
`define CCD_OPT0_FSEL_W   6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCD_CMD_RST       5'h00
`define CCD_FSEL_RST      6'h00
`define CCD_FLASH_START   32'h0000_0000

`endif

// ==== rtl/ccd_pkg.sv ====
// Purpose: Types shared by the command decoder files
// Assumes: ccd_map.svh supplies the command codes and field widths
// Notes:   Command enum values come from the map header
`include "ccd_map.svh"

package ccd_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	typedef enum logic [`CCD_CMD_W-1:0] {
		CCD_NULL     = `CCD_C_NULL,
		CCD_WRITE    = `CCD_C_WRITE,
		CCD_MULTI    = `CCD_C_MULTI,
		CCD_LAST     = `CCD_C_LAST,
		CCD_READ     = `CCD_C_READ,
		CCD_START    = `CCD_C_START,
		CCD_ULTRA_RAM_CLEAR_COMMAND     = `CCD_C_ULTRA_RAM_CLEAR_COMMAND,
		CCD_CRCRST   = `CCD_C_CRCRST,
		CCD_HOLD     = `CCD_C_HOLD,
		CCD_SWITCH   = `CCD_C_SWITCH,
		CCD_RESTORE  = `CCD_C_RESTORE,
		CCD_SHUTDOWN = `CCD_C_SHUTDOWN,
		CCD_DESYNCHRONIZE_COMMAND   = `CCD_C_DESYNCHRONIZE_COMMAND,
		CCD_WARMBOOT = `CCD_C_WARMBOOT,
		CCD_RECALC   = `CCD_C_RECALC,
		CCD_REREAD   = `CCD_C_REREAD,
		CCD_FALLEDGE = `CCD_C_FALLEDGE
	} ccd_cmd_t;

	// ----------------------------------------------------------------
	// Frame access mode, Gray coded along idle-write-multi-read
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CCD_M_IDLE  = 2'h0,
		CCD_M_WRITE = 2'h1,
		CCD_M_MULTI = 2'h3,
		CCD_M_READ  = 2'h2
	} ccd_mode_t;

	// Flash master mode of the configuration port
	typedef enum logic [1:0] {
		CCD_F_NONE = 2'h0,
		CCD_F_SPI  = 2'h1,
		CCD_F_BPI  = 2'h2
	} ccd_flash_t;

	// One-cycle strobes to the controlled units
	typedef struct packed {
		logic ultra_ram_clear_command_clear;
		logic checksum_reset;
		logic clock_switch;
		logic flop_restore;
		logic warm_boot;
		logic checksum_recalc;
		logic flash_reread;
		logic startup_go;
		logic shutdown_go;
	} ccd_strobe_t;

	// Clock settings sent with the clock switch strobe
	typedef struct packed {
		logic                       ext_clk_en;
		logic [`CCD_OPT0_FSEL_W-1:0] osc_sel;
	} ccd_clk_t;

	// One-hot decode of the held command
	typedef struct packed {
		logic write, multi, last, read, start, ultra_ram_clear_command, crcrst, hold;
		logic swtch, restore, shutdown, desynchronize_command, warmboot, recalc;
		logic reread, falledge;
	} ccd_dec_t;

endpackage

// ==== rtl/ccd_exec.sv ====
// Purpose: Decodes the held command into one-hot execute lines
// Assumes: Purely combinational, same clock as the caller
// Notes:   Lines are only active in the cycle of a frame address load
`timescale 1ns/1ps
`include "ccd_map.svh"

module ccd_exec
	import ccd_pkg::*;
(
	// Command and trigger
	input  wire logic [`CCD_CMD_W-1:0] cmd,
	input  wire logic                  fire,
	// Decoded lines
	output ccd_dec_t                   dec
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Codes outside the enum match no item and leave every line low
	always_comb begin
		dec = '0;
		if (fire) begin
			unique case (cmd)
				CCD_NULL:     dec = '0;
				CCD_WRITE:    dec.write    = 1'b1;
				CCD_MULTI:    dec.multi    = 1'b1;
				CCD_LAST:     dec.last     = 1'b1;
				CCD_READ:     dec.read     = 1'b1;
				CCD_START:    dec.start    = 1'b1;
				CCD_ULTRA_RAM_CLEAR_COMMAND:     dec.ultra_ram_clear_command     = 1'b1;
				CCD_CRCRST:   dec.crcrst   = 1'b1;
				CCD_HOLD:     dec.hold     = 1'b1;
				CCD_SWITCH:   dec.swtch    = 1'b1;
				CCD_RESTORE:  dec.restore  = 1'b1;
				CCD_SHUTDOWN: dec.shutdown = 1'b1;
				CCD_DESYNCHRONIZE_COMMAND:   dec.desynchronize_command   = 1'b1;
				CCD_WARMBOOT: dec.warmboot = 1'b1;
				CCD_RECALC:   dec.recalc   = 1'b1;
				CCD_REREAD:   dec.reread   = 1'b1;
				CCD_FALLEDGE: dec.falledge = 1'b1;
				default:      dec = '0;
			endcase
		end
	end

endmodule

// ==== rtl/ccd_top.sv ====
// Purpose: Command register and command execution of the configuration control logic
// Assumes: Register port driven by the packet parser on the configuration clock
// Notes:   Strobes appear one cycle after the frame address load that fires them
`timescale 1ns/1ps
`include "ccd_map.svh"

module ccd_top
	import ccd_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// Register port from the packet parser
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	input  wire logic [4:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	output logic      [31:0]           reg_rdata,
	// Checksum unit and word aligner
	input  wire logic [31:0]           crc_calc,
	input  wire logic                  sync_found,
	// Flash master status
	input  ccd_flash_t                 flash_mode,
	input  wire logic                  spi_format_changed,
	input  wire logic                  bpi_sync_switched,
	// Held modes
	output ccd_mode_t                  frame_mode,
	output logic                       interconnect_hold_n,
	output logic                       word_alignment_flag,
	output logic                       data_ignore,
	output logic                       falling_edge_capture,
	output logic                       crc_error,
	// Strobes and their data
	output ccd_strobe_t                strobe,
	output ccd_clk_t                   clk_setting,
	output logic      [31:0]           flash_addr
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [`CCD_CMD_W-1:0] command_register;      // Held command
	logic [`CCD_CMD_W-1:0] next_command_register;
	ccd_clk_t              opt0;                  // Snooped option register 0 fields
	ccd_clk_t              next_opt0;
	logic [31:0]           next_reg_rdata;
	ccd_dec_t              dec;                   // Decoded execute lines
	logic                  far_load;              // Frame address load this cycle
	logic                  crc_wr;                // Checksum register written
	logic                  crc_match;             // Written value equals calculated

	ccd_mode_t             next_frame_mode;
	logic                  next_hold_n;
	logic                  next_align;
	logic                  next_falling;
	logic                  next_crc_error;
	logic                  start_armed;           // Start-up waiting for its conditions
	logic                  next_start_armed;
	logic                  crc_ok;                // A matching checksum has been seen
	logic                  next_crc_ok;
	logic                  desynchronize_command_done;           // Desynchronize has executed
	logic                  next_desynchronize_command_done;
	logic                  shut_armed;            // Shutdown waiting for its trigger
	logic                  next_shut_armed;
	ccd_strobe_t           next_strobe;
	ccd_clk_t              next_clk_setting;
	logic                  hold_toggle;           // Hold level about to change

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// True when a write strobe hits the given register address
	function automatic logic hit(input logic wr, input logic [4:0] a, input logic [4:0] target);
		hit = wr && (a == target);
	endfunction

	assign far_load  = hit(reg_wr, reg_addr, `CCD_ADDR_FAR);
	assign crc_wr    = hit(reg_wr, reg_addr, `CCD_ADDR_CRC);
	assign crc_match = crc_wr && (reg_wdata == crc_calc);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	ccd_exec u_exec (
		.cmd  (command_register),
		.fire (far_load),
		.dec  (dec)
	);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Command register stores, option fields are snooped, reads return the held command
	always_comb begin
		next_command_register = command_register;
		next_opt0             = opt0;
		next_reg_rdata        = reg_rdata;
		if (hit(reg_wr, reg_addr, `CCD_ADDR_CMD)) begin
			next_command_register = reg_wdata[`CCD_CMD_W-1:0];
		end
		// Option bits are kept here so the switch needs no extra port
		if (hit(reg_wr, reg_addr, `CCD_ADDR_OPT0)) begin
			next_opt0.ext_clk_en = reg_wdata[`CCD_OPT0_ECLK_BIT];
			next_opt0.osc_sel    = reg_wdata[`CCD_OPT0_FSEL_LSB +: `CCD_OPT0_FSEL_W];
		end
		if (reg_rd) begin
			// Other addresses belong to other units and read as zero here
			if (reg_addr == `CCD_ADDR_CMD) begin
				next_reg_rdata = {27'h0000000, command_register};
			end else begin
				next_reg_rdata = 32'h0000_0000;
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			command_register <= `CCD_CMD_RST;
			opt0             <= '{ext_clk_en: 1'b0, osc_sel: `CCD_FSEL_RST};
			reg_rdata        <= 32'h0000_0000;
		end else begin
			command_register <= next_command_register;
			opt0             <= next_opt0;
			reg_rdata        <= next_reg_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Held modes
	// ----------------------------------------------------------------
	// Frame mode, interconnect hold, alignment and capture edge
	always_comb begin
		next_frame_mode = frame_mode;
		next_hold_n     = interconnect_hold_n;
		next_align      = word_alignment_flag;
		next_falling    = falling_edge_capture;
		next_crc_error  = crc_error;
		unique case (frame_mode)
			CCD_M_IDLE, CCD_M_WRITE, CCD_M_MULTI, CCD_M_READ: begin
				// Write, multi and read modes may each be entered from any mode; idle only by reset
				if (dec.write) begin
					next_frame_mode = CCD_M_WRITE;
				end else if (dec.multi) begin
					next_frame_mode = CCD_M_MULTI;
				end else if (dec.read) begin
					next_frame_mode = CCD_M_READ;
				end
			end
		endcase
		if (dec.hold) begin
			next_hold_n = 1'b0;
		end else if (dec.last) begin
			next_hold_n = 1'b1;
		end
		// Aligner set wins over a desynchronize_command in the same cycle
		if (sync_found) begin
			next_align = 1'b1;
		end else if (dec.desynchronize_command) begin
			next_align = 1'b0;
		end
		if (dec.falledge) begin
			next_falling = 1'b1;
		end
		if (crc_wr) begin
			next_crc_error = !crc_match;
		end
	end

	// Data is ignored while the aligner is out of sync
	assign data_ignore = !word_alignment_flag;

	// Held mode flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_mode           <= CCD_M_IDLE;
			interconnect_hold_n  <= 1'b1;
			word_alignment_flag  <= 1'b0;
			falling_edge_capture <= 1'b0;
			crc_error            <= 1'b0;
		end else begin
			frame_mode           <= next_frame_mode;
			interconnect_hold_n  <= next_hold_n;
			word_alignment_flag  <= next_align;
			falling_edge_capture <= next_falling;
			crc_error            <= next_crc_error;
		end
	end

	// ----------------------------------------------------------------
	// Start-up and shutdown arming
	// ----------------------------------------------------------------
	// Start-up fires once armed, a match is seen and desynchronize_command has run
	always_comb begin
		next_start_armed = start_armed;
		next_crc_ok      = crc_ok;
		next_desynchronize_command_done = desynchronize_command_done;
		next_shut_armed  = shut_armed;
		if (dec.start) begin
			next_start_armed = 1'b1;
		end
		// A checksum reset withdraws an earlier match, a new match wins
		if (crc_match) begin
			next_crc_ok = 1'b1;
		end else if (dec.crcrst || crc_wr) begin
			next_crc_ok = 1'b0;
		end
		if (dec.desynchronize_command) begin
			next_desynchronize_command_done = 1'b1;
		end
		if (next_strobe.startup_go) begin
			next_start_armed = 1'b0;
			next_desynchronize_command_done = 1'b0;
		end
		if (dec.shutdown) begin
			next_shut_armed = 1'b1;
		end else if (next_strobe.shutdown_go) begin
			next_shut_armed = 1'b0;
		end
	end

	// Arming flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_armed <= 1'b0;
			crc_ok      <= 1'b0;
			desynchronize_command_done <= 1'b0;
			shut_armed  <= 1'b0;
		end else begin
			start_armed <= next_start_armed;
			crc_ok      <= next_crc_ok;
			desynchronize_command_done <= next_desynchronize_command_done;
			shut_armed  <= next_shut_armed;
		end
	end

	// ----------------------------------------------------------------
	// Strobes
	// ----------------------------------------------------------------
	// A hold level change also counts as a recalc request
	assign hold_toggle = (next_hold_n != interconnect_hold_n);

	// Every strobe is high for exactly one cycle
	always_comb begin
		next_strobe                 = '0;
		next_clk_setting            = clk_setting;
		next_strobe.ultra_ram_clear_command_clear      = dec.ultra_ram_clear_command;
		next_strobe.checksum_reset  = dec.crcrst;
		next_strobe.flop_restore    = dec.restore;
		next_strobe.warm_boot       = dec.warmboot;
		next_strobe.checksum_recalc = dec.recalc || hold_toggle;
		next_strobe.clock_switch    = dec.swtch;
		if (dec.swtch) begin
			next_clk_setting = opt0;
		end
		// Reread only when the flash master is in the matching state
		if (dec.reread) begin
			if (flash_mode == CCD_F_SPI) begin
				next_strobe.flash_reread = spi_format_changed;
			end else if (flash_mode == CCD_F_BPI) begin
				next_strobe.flash_reread = bpi_sync_switched;
			end
		end
		// Start-up needs all three conditions at once
		next_strobe.startup_go  = (start_armed || dec.start) && crc_ok && (desynchronize_command_done || dec.desynchronize_command);
		// Shutdown goes on a match or a checksum reset after arming
		next_strobe.shutdown_go = shut_armed && (crc_match || dec.crcrst);
	end

	// Strobe flops, and the fixed restart address for the flash master
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strobe      <= '0;
			clk_setting <= '{ext_clk_en: 1'b0, osc_sel: `CCD_FSEL_RST};
			flash_addr  <= `CCD_FLASH_START;
		end else begin
			strobe      <= next_strobe;
			clk_setting <= next_clk_setting;
			flash_addr  <= `CCD_FLASH_START;
		end
	end

endmodule

// ==== bench/ccd_top_assertions.sv ====
// Purpose: Concurrent checks on the ports of the command decoder
// Assumes: Single clock domain, async active-low reset
// Notes:   Shadow registers track the command and clock option writes
`timescale 1ns/1ps

module ccd_top_assertions
	import ccd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic [31:0] reg_rdata,
	// Checksum, aligner and flash status
	input  wire logic [31:0] crc_calc,
	input  wire logic        sync_found,
	input  ccd_flash_t       flash_mode,
	input  wire logic        spi_format_changed,
	input  wire logic        bpi_sync_switched,
	// Held modes
	input  ccd_mode_t        frame_mode,
	input  wire logic        interconnect_hold_n,
	input  wire logic        word_alignment_flag,
	input  wire logic        data_ignore,
	input  wire logic        falling_edge_capture,
	input  wire logic        crc_error,
	// Strobes and their data
	input  ccd_strobe_t      strobe,
	input  ccd_clk_t         clk_setting,
	input  wire logic [31:0] flash_addr
);
	logic [4:0] cmd_q;  // Shadow of the command register
	ccd_clk_t   opt_q;  // Shadow of the clock option fields
	logic       fire;   // Frame address load
	assign fire = reg_wr && (reg_addr == 5'h01);

	// ----------------------------------------------------------------
	// Shadow registers; a write to CMD never coincides with a load
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmd_q <= 5'h00;
			opt_q <= '0;
		end else if (reg_wr && reg_addr == 5'h04) begin
			cmd_q <= reg_wdata[4:0];
		end else if (reg_wr && reg_addr == 5'h09) begin
			opt_q <= {reg_wdata[0], reg_wdata[6:1]};
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	null_cmd_a: assert property (fire && cmd_q == CCD_NULL |=> strobe == '0 && $stable(frame_mode))
		else $error("null command changed the outputs");
	ultra_ram_clear_command_clear_a: assert property (strobe.ultra_ram_clear_command_clear == $past(fire && cmd_q == CCD_ULTRA_RAM_CLEAR_COMMAND))
		else $error("ram clear strobe not tied to a load");
	crc_reset_a: assert property (strobe.checksum_reset == $past(fire && cmd_q == CCD_CRCRST))
		else $error("checksum reset strobe wrong");
	restore_pulse_a: assert property (fire && cmd_q == CCD_RESTORE |=> strobe.flop_restore ##1 !strobe.flop_restore)
		else $error("restore pulse wrong");
	warm_boot_a: assert property (strobe.warm_boot |-> $past(fire && cmd_q == CCD_WARMBOOT))
		else $error("warm boot without its command");
	write_mode_a: assert property (fire && cmd_q == CCD_WRITE |=> frame_mode == CCD_M_WRITE)
		else $error("write mode not entered");
	multi_mode_a: assert property (fire && cmd_q == CCD_MULTI |=> frame_mode == CCD_M_MULTI)
		else $error("multi write mode not entered");
	read_mode_a: assert property (fire && cmd_q == CCD_READ |=> frame_mode == CCD_M_READ)
		else $error("read mode not entered");
	hold_release_a: assert property (fire && cmd_q == CCD_LAST |=> interconnect_hold_n)
		else $error("hold not released");
	hold_assert_a: assert property (fire && cmd_q == CCD_HOLD && interconnect_hold_n
		|=> !interconnect_hold_n && strobe.checksum_recalc)
		else $error("hold or recalc wrong");
	clock_switch_a: assert property (fire && cmd_q == CCD_SWITCH |=> strobe.clock_switch && clk_setting == opt_q)
		else $error("clock switch settings wrong");
	desynchronize_command_a: assert property (fire && cmd_q == CCD_DESYNCHRONIZE_COMMAND && !sync_found |=> !word_alignment_flag && data_ignore)
		else $error("desynchronize_command did not clear alignment");
	fall_edge_a: assert property (fire && cmd_q == CCD_FALLEDGE |=> falling_edge_capture)
		else $error("falling edge capture not set");
	unassigned_a: assert property (fire && (cmd_q inside {5'h0C, 5'h0E, 5'h11} || cmd_q > 5'h13) |=> strobe == '0)
		else $error("unassigned code strobed");
	startup_once_a: assert property (strobe.startup_go |=> !strobe.startup_go)
		else $error("start-up strobe longer than one cycle");
endmodule

// ==== bench/ccd_source.sv ====
// Purpose: Bitstream source model driving register packets
// Assumes: Requests launched on the falling edge, taken on the rising edge
// Notes:   Released address and data show inverted values, never stale ones
`timescale 1ns/1ps

module ccd_source (
	// Clock
	input  wire logic        clk,
	// Register port toward the decoder
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [4:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	// Read answer
	input  wire logic [31:0] reg_rdata,
	output logic      [31:0] rd_data
);
	// Idle bus at time zero
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 5'h1F;
		reg_wdata = 32'hFFFF_FFFF;
		rd_data   = 32'h0;
	end

	// ----------------------------------------------------------------
	// One access; the read answer is taken on the following falling edge
	// ----------------------------------------------------------------
	task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_wr    = wr;
		reg_rd    = !wr;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge clk);
		@(negedge clk);
		rd_data   = reg_rdata;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// ==== bench/ccd_top_tb.sv ====
// Purpose: Self-checking bench of the command decoder
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes:   Outputs are sampled one cycle after the load that fires them
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end

module ccd_top_tb
	import ccd_pkg::*;
;
	logic        clk, nrst, sync_found, spi_format_changed, bpi_sync_switched;
	logic        reg_wr, reg_rd, interconnect_hold_n, word_alignment_flag;
	logic        data_ignore, falling_edge_capture, crc_error;
	logic [4:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, crc_calc, flash_addr, rdv;
	ccd_flash_t  flash_mode;
	ccd_mode_t   frame_mode;
	ccd_strobe_t strobe;
	ccd_clk_t    clk_setting;
	int          n_mismatch = 0;
	int          checks = 0;
	// Pulse commands and their strobe patterns
	logic [4:0]  sc [6] = '{CCD_ULTRA_RAM_CLEAR_COMMAND, CCD_CRCRST, CCD_RESTORE, CCD_WARMBOOT, CCD_RECALC, CCD_SWITCH};
	logic [8:0]  se [6] = '{9'h100, 9'h080, 9'h020, 9'h010, 9'h008, 9'h040};
	// Mode commands, unassigned codes and null, with the mode left behind
	logic [4:0]  mc [9] = '{CCD_WRITE, CCD_MULTI, CCD_READ, 5'h0C, 5'h0E, 5'h11, 5'h14, 5'h1F, CCD_NULL};
	ccd_mode_t   me [9] = '{CCD_M_WRITE, CCD_M_MULTI, CCD_M_READ, CCD_M_READ, CCD_M_READ,
		CCD_M_READ, CCD_M_READ, CCD_M_READ, CCD_M_READ};

	always #50 clk = ~clk;

	ccd_source u_src (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rd_data(rdv));

	ccd_top u_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .crc_calc(crc_calc), .sync_found(sync_found),
		.flash_mode(flash_mode), .spi_format_changed(spi_format_changed),
		.bpi_sync_switched(bpi_sync_switched), .frame_mode(frame_mode),
		.interconnect_hold_n(interconnect_hold_n), .word_alignment_flag(word_alignment_flag),
		.data_ignore(data_ignore), .falling_edge_capture(falling_edge_capture), .crc_error(crc_error),
		.strobe(strobe), .clk_setting(clk_setting), .flash_addr(flash_addr));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Load a command, then fire it with a frame address load
	task automatic exec(input logic [4:0] c);
		u_src.access(1'b1, 5'h04, {27'h0, c});
		u_src.access(1'b1, 5'h01, 32'h0);
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog; the full sequence needs well under 400 cycles
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		crc_calc = 32'h1234_ABCD;
		sync_found = 1'b0;
		flash_mode = CCD_F_NONE;
		spi_format_changed = 1'b0;
		bpi_sync_switched = 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		`CHK("mode", CCD_M_IDLE, frame_mode)
		`CHK("hold_n", 1'b1, interconnect_hold_n)
		`CHK("ignore", 1'b1, data_ignore)
		u_src.access(1'b0, 5'h04, 32'h0);
		`CHK("cmd_reset", 32'h0, rdv)
		sync_found = 1'b1;
		@(negedge clk);
		sync_found = 1'b0;
		`CHK("align", 1'b1, word_alignment_flag)
		u_src.access(1'b1, 5'h09, 32'h0000_0035);
		// Each pulse command strobes once and again on a second load
		for (int i = 0; i < 6; i++) begin
			exec(sc[i]);
			`CHK("strobe", se[i], strobe)
			@(negedge clk);
			`CHK("strobe_end", 9'h000, strobe)
			u_src.access(1'b1, 5'h01, 32'h0);
			`CHK("reload", se[i], strobe)
		end
		`CHK("clk_set", 7'h5A, clk_setting)
		// Held modes; unassigned and null codes leave them alone
		for (int i = 0; i < 9; i++) begin
			exec(mc[i]);
			`CHK("mode", me[i], frame_mode)
			`CHK("quiet", 9'h000, strobe)
		end
		// Hold and release, each toggle recalculates
		exec(CCD_HOLD);
		`CHK("hold_n", 1'b0, interconnect_hold_n)
		`CHK("recalc", 9'h008, strobe)
		exec(CCD_LAST);
		`CHK("hold_n", 1'b1, interconnect_hold_n)
		`CHK("recalc", 9'h008, strobe)
		// Start-up needs arm, desynchronize_command and a checksum match
		exec(CCD_START);
		`CHK("armed", 9'h000, strobe)
		exec(CCD_DESYNCHRONIZE_COMMAND);
		`CHK("align", 1'b0, word_alignment_flag)
		`CHK("ignore", 1'b1, data_ignore)
		u_src.access(1'b1, 5'h00, crc_calc);
		`CHK("crc_err", 1'b0, crc_error)
		// The match is registered first, so start-up follows one cycle later
		@(negedge clk);
		`CHK("startup", 9'h002, strobe)
		u_src.access(1'b1, 5'h00, ~crc_calc);
		`CHK("crc_err", 1'b1, crc_error)
		// Shutdown waits for a checksum reset
		exec(CCD_SHUTDOWN);
		`CHK("armed", 9'h000, strobe)
		exec(CCD_CRCRST);
		`CHK("shutdown", 9'h081, strobe)
		// Flash re-read only under the right flash conditions
		flash_mode = CCD_F_SPI;
		spi_format_changed = 1'b1;
		exec(CCD_REREAD);
		`CHK("reread", 9'h004, strobe)
		`CHK("flash_addr", 32'h0, flash_addr)
		flash_mode = CCD_F_BPI;
		u_src.access(1'b1, 5'h01, 32'h0);
		`CHK("no_reread", 9'h000, strobe)
		bpi_sync_switched = 1'b1;
		u_src.access(1'b1, 5'h01, 32'h0);
		`CHK("reread", 9'h004, strobe)
		exec(CCD_FALLEDGE);
		`CHK("fall", 1'b1, falling_edge_capture)
		u_src.access(1'b0, 5'h04, 32'h0);
		`CHK("cmd_rd", 32'h0000_0013, rdv)
		u_src.access(1'b0, 5'h1F, 32'h0);
		`CHK("unmapped", 32'h0, rdv)
		print_verdict();
	end
endmodule

bind ccd_top ccd_top_assertions u_chk (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .crc_calc(crc_calc),
	.sync_found(sync_found), .flash_mode(flash_mode), .spi_format_changed(spi_format_changed),
	.bpi_sync_switched(bpi_sync_switched), .frame_mode(frame_mode),
	.interconnect_hold_n(interconnect_hold_n), .word_alignment_flag(word_alignment_flag),
	.data_ignore(data_ignore), .falling_edge_capture(falling_edge_capture), .crc_error(crc_error),
	.strobe(strobe), .clk_setting(clk_setting), .flash_addr(flash_addr));
